// ==== udc_pause_crc.sv ====
// Device end of the burst: pause flow control, word CRC and CRC check
`timescale 1ns/1ps

// Summary of operation
// [R01] Recipient pauses by negating its ready
// [R02] Ready may return at once, no minimum
// [R03] Ready thresholds use hysteresis on fill level
// [R04] Accept two or three words after negation
// [R05] Sender stops strobing once host ready drops
// [R06] Incoming host ready passes a synchroniser
// [R07] Paused word may sit on lines, unstrobed
// [R08] Unstrobed held word is handed back at end
// [R09] Keep taking strobes until pause settle time
// [R10] Near-full threshold leaves room for latency
// [R11] Any count of extra words is accepted
// [R12] CRC advances on every data strobe edge
// [R13] Terminating strobe re-assertion when left low
// [R14] Terminating strobe and unsent words skip CRC
// [R15] CRC and word capture share one sampled clock
// [R16] CRC preset to 4ABA before first word
// [R17] CRC bit n maps to data line n
// [R18] Host CRC compared after every burst
// [R19] Received CRC latched then compared digitally
// [R20] Host moves one word before terminating
// [R21] CRC uses x16+x12+x5+1 over whole word
// [R22] Mismatch raises the interface CRC error
module udc_pause_crc
   import udc_pkg::*;
#(
   parameter int FILL_W    = 8,                  // Width of the buffer fill count
   parameter int BUF_DEPTH = 64,                 // Words in the user receive buffer
   parameter int FILL_HIGH = BUF_DEPTH - EXTRA_WORDS_FAST - PIPE_WORDS, // Pause level
   parameter int FILL_LOW  = BUF_DEPTH / 2       // Resume level
) (
   // System clock domain
   input  wire logic              ref_clk,
   input  wire logic              rst,
   // Link clock domain
   input  wire logic              linkClk,
   // Connector pins
   input  wire udc_pin_in_t       pinsIn,
   output udc_pin_out_t           pinsOut,
   // Burst control from user logic
   input  wire logic              burstReq,
   input  wire logic              dirIn,
   // Receive side user buffer
   input  wire logic [FILL_W-1:0] fillLevel,
   output logic                   rxValid,
   output logic [WORD_W-1:0]      rxWord,
   // Transmit side words
   input  wire logic              txValid,
   input  wire logic [WORD_W-1:0] txWord,
   output logic                   txReady,
   output logic                   txRewind,
   // Burst result
   output logic                   burstDone,
   output logic                   crcError
);

   // Fill thresholds at the fill count width
   localparam logic [FILL_W-1:0] FILL_HI = FILL_W'(FILL_HIGH);
   localparam logic [FILL_W-1:0] FILL_LO = FILL_W'(FILL_LOW);

   // Parallel CRC over one word, bit n of data on line n
   function automatic logic [15:0] crc_step(input logic [15:0] crcIn,
                                            input logic [15:0] dataIn);
      logic [15:0] acc;
      logic        fb;
      acc = crcIn;
      for (int i = WORD_W - 1; i >= 0; i--) begin
         fb  = acc[15] ^ dataIn[i];
         acc = {acc[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
      end
      return acc;
   endfunction

   // ---------------- System domain signals ----------------
   logic                 spaceOk_reg;     // Hysteresis ready level
   logic                 txIdle_reg;      // Holding word free
   logic [WORD_W-1:0]    txWord_reg;      // Word handed to the link
   logic                 txReqTgl_reg;    // Toggles per handed word
   logic [1:0]           txAckS_reg;      // Ack toggle synchroniser
   logic [2:0]           doneS_reg;       // Done toggle sync plus history
   logic [2:0]           rewS_reg;        // Rewind toggle sync plus history
   logic [1:0]           wrGrayS1_reg;    // Write pointer sync stage 1
   logic [1:0]           wrGrayS2_reg;    // Write pointer sync stage 2
   logic [1:0]           rdPtr_reg;       // Receive read pointer
   logic                 rxValid_reg;     // Word out valid
   logic [WORD_W-1:0]    rxWord_reg;      // Word out
   logic                 txRewind_reg;    // Rewind pulse
   logic                 burstDone_reg;   // Done pulse
   logic                 crcError_reg;    // Latched comparison result
   logic [1:0]           wrPtrSeen;       // Synced write pointer, binary

   // ---------------- Link domain signals ----------------
   logic                 rstS1_reg;       // Reset synchroniser stage 1
   logic                 linkRst_reg;     // Reset in the link domain
   udc_pin_in_t          pinS1_reg;       // Pin synchroniser stage 1
   udc_pin_in_t          pinS2_reg;       // Pin synchroniser stage 2
   logic                 hStrobePrev_reg; // Previous synced host strobe
   logic [2:0]           ctlS1_reg;       // Control level sync stage 1
   logic [2:0]           ctlS2_reg;       // Control level sync stage 2
   logic [1:0]           txReqS_reg;      // Word request toggle sync
   udc_state_t           state_reg;       // Burst state
   logic                 dmarq_reg;       // Burst request pin
   logic                 dReadyN_reg;     // Device ready pin
   logic                 dStrobe_reg;     // Device strobe pin
   logic [WORD_W-1:0]    ddOut_reg;       // Data out lines
   logic                 ddOe_reg;        // Data out enable
   logic [3:0]           pauseCnt_reg;    // Pause settle countdown
   logic [15:0]          crc_reg;         // Running CRC
   logic [15:0]          crcIn_reg;       // Received host CRC
   logic                 crcErrL_reg;     // Comparison result
   logic                 doneTgl_reg;     // Burst end event
   logic                 rewTgl_reg;      // Held word discarded event
   logic                 txAckTgl_reg;    // Word taken event
   logic [WORD_W-1:0]    txHold_reg;      // Word waiting to be strobed
   logic                 txHoldV_reg;     // Holding word valid
   logic                 shown_reg;       // Held word already on lines
   logic [1:0]           wrPtr_reg;       // Receive write pointer, binary
   logic [1:0]           wrGray_reg;      // Receive write pointer, gray
   logic [WORD_W-1:0]    rxSlot [2**RX_SLOT_W]; // Receive crossing slots

   logic                 burstReqL;       // Synced burst request
   logic                 dirInL;          // Synced direction, 1 = device sends
   logic                 spaceOkL;        // Synced buffer space level
   logic                 hostPaused;      // Host ready negated, synced
   logic                 rxEdge;          // Data strobe edge from host
   logic                 txFire;          // Device strobe edge with data
   logic                 settled;         // Pause settle time has run out
   logic [1:0]           wrPtrInc;        // Next write pointer

   assign burstReqL  = ctlS2_reg[0];
   assign dirInL     = ctlS2_reg[1];
   assign spaceOkL   = ctlS2_reg[2];
   assign hostPaused = pinS2_reg.hReadyN;                               // [R06]
   assign settled    = dReadyN_reg && (pauseCnt_reg == PAUSE_CNT_ZERO);
   assign wrPtrInc   = wrPtr_reg + RX_PTR_ONE;
   assign wrPtrSeen  = {wrGrayS2_reg[1], wrGrayS2_reg[1] ^ wrGrayS2_reg[0]};

   // Host strobe edge in the transfer phase; stop marks the empty edge
   assign rxEdge = (state_reg == ST_XFER) && !dirInL && !pinS2_reg.stop &&
                   (pinS2_reg.hStrobe ^ hStrobePrev_reg);              // [R12] [R14]

   // Device strobe edge once the word has stood a cycle on the lines
   assign txFire = (state_reg == ST_XFER) && dirInL && txHoldV_reg && shown_reg &&
                   !hostPaused && burstReqL && !pinS2_reg.stop;        // [R05] [R07]

   // Pin outputs, each straight from a flop
   assign pinsOut = '{dmarq: dmarq_reg, dReadyN: dReadyN_reg, dStrobe: dStrobe_reg,
                      dd: ddOut_reg, ddOe: ddOe_reg};
   assign rxValid   = rxValid_reg;
   assign rxWord    = rxWord_reg;
   assign txReady   = txIdle_reg;
   assign txRewind  = txRewind_reg;
   assign burstDone = burstDone_reg;
   assign crcError  = crcError_reg;

   // ================= System domain =================

   // Ready level with hysteresis on the user buffer fill
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         spaceOk_reg <= 1'b1;
      end else if (fillLevel >= FILL_HI) begin
         spaceOk_reg <= 1'b0;                                           // [R03] [R10]
      end else if (fillLevel <= FILL_LO) begin
         spaceOk_reg <= 1'b1;                                           // [R03]
      end
   end

   // Transmit word handover by request and acknowledge toggles
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         txIdle_reg   <= 1'b1;
         txWord_reg   <= '0;
         txReqTgl_reg <= 1'b0;
         txAckS_reg   <= '0;
      end else begin
         txAckS_reg <= {txAckS_reg[0], txAckTgl_reg};
         if (txValid && txIdle_reg) begin
            // Word held stable until the link acknowledges it
            txWord_reg   <= txWord;
            txReqTgl_reg <= !txReqTgl_reg;
            txIdle_reg   <= 1'b0;
         end else if (!txIdle_reg && (txAckS_reg[1] == txReqTgl_reg)) begin
            txIdle_reg <= 1'b1;
         end
      end
   end

   // Receive words through gray pointer crossing
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wrGrayS1_reg <= '0;
         wrGrayS2_reg <= '0;
         rdPtr_reg    <= '0;
         rxValid_reg  <= 1'b0;
         rxWord_reg   <= '0;
      end else begin
         wrGrayS1_reg <= wrGray_reg;
         wrGrayS2_reg <= wrGrayS1_reg;
         rxValid_reg  <= 1'b0;
         if (wrPtrSeen != rdPtr_reg) begin
            // One word per cycle drains faster than the link can fill
            rxWord_reg  <= rxSlot[rdPtr_reg];                           // [R11]
            rxValid_reg <= 1'b1;
            rdPtr_reg   <= rdPtr_reg + RX_PTR_ONE;
         end
      end
   end

   // Burst end and rewind events into one-cycle pulses
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         doneS_reg     <= '0;
         rewS_reg      <= '0;
         burstDone_reg <= 1'b0;
         txRewind_reg  <= 1'b0;
         crcError_reg  <= 1'b0;
      end else begin
         doneS_reg     <= {doneS_reg[1:0], doneTgl_reg};
         rewS_reg      <= {rewS_reg[1:0], rewTgl_reg};
         burstDone_reg <= doneS_reg[2] ^ doneS_reg[1];
         txRewind_reg  <= rewS_reg[2] ^ rewS_reg[1];                    // [R08]
         if (doneS_reg[2] ^ doneS_reg[1]) begin
            // Result was set on the same edge as the done toggle and has settled before it is seen here
            crcError_reg <= crcErrL_reg;                                // [R22]
         end
      end
   end

   // ================= Link domain =================

   // Reset, pin and control level synchronisers
   always_ff @(posedge linkClk) begin
      rstS1_reg       <= rst;
      linkRst_reg     <= rstS1_reg;
      pinS1_reg       <= pinsIn;
      pinS2_reg       <= pinS1_reg;                                     // [R06] [R15]
      hStrobePrev_reg <= pinS2_reg.hStrobe;
      ctlS1_reg       <= {spaceOk_reg, dirIn, burstReq};
      ctlS2_reg       <= ctlS1_reg;
      txReqS_reg      <= {txReqS_reg[0], txReqTgl_reg};
   end

   // Burst sequence: request, transfer, termination, CRC check
   always_ff @(posedge linkClk) begin
      if (linkRst_reg) begin
         state_reg   <= ST_IDLE;
         dmarq_reg   <= 1'b0;
         crcIn_reg   <= '0;
         crcErrL_reg <= 1'b0;
         doneTgl_reg <= 1'b0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (burstReqL) begin
                  dmarq_reg <= 1'b1;
                  state_reg <= ST_WAIT_ACK;
               end
            end
            ST_WAIT_ACK: begin
               if (!pinS2_reg.dmackN) begin
                  state_reg <= ST_XFER;
               end
            end
            ST_XFER: begin
               if (!dirInL) begin
                  if (pinS2_reg.stop) begin
                     // Host ends the data-out burst
                     dmarq_reg <= 1'b0;
                     state_reg <= ST_RELEASE;
                  end else if (!burstReqL && settled) begin
                     // Device ends only after the pause has settled
                     dmarq_reg <= 1'b0;                                 // [R09]
                     state_reg <= ST_RELEASE;
                  end
               end else if (pinS2_reg.stop || !burstReqL) begin
                  dmarq_reg <= 1'b0;
                  state_reg <= ST_END_STROBE;
               end
            end
            ST_END_STROBE: begin
               state_reg <= ST_RELEASE;
            end
            default: begin
               if (pinS2_reg.dmackN) begin
                  // Host drives its CRC as it releases acknowledge
                  crcIn_reg   <= pinS2_reg.dd;                          // [R18] [R19]
                  crcErrL_reg <= (pinS2_reg.dd != crc_reg);             // [R19] [R22]
                  doneTgl_reg <= !doneTgl_reg;
                  state_reg   <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // Device ready pin and pause settle countdown
   always_ff @(posedge linkClk) begin
      if (linkRst_reg) begin
         dReadyN_reg  <= 1'b1;
         pauseCnt_reg <= PAUSE_CNT_ZERO;
      end else begin
         if ((state_reg == ST_XFER) && !dirInL) begin
            // Ready follows space at once in data-out bursts only; held negated otherwise
            dReadyN_reg <= !(spaceOkL && burstReqL);                    // [R01] [R02]
         end else begin
            dReadyN_reg <= 1'b1;
         end
         if (!dReadyN_reg && !((state_reg == ST_XFER) && !dirInL && spaceOkL && burstReqL)) begin
            pauseCnt_reg <= PAUSE_SETTLE_CNT;                           // [R09]
         end else if (pauseCnt_reg != PAUSE_CNT_ZERO) begin
            pauseCnt_reg <= pauseCnt_reg - 4'h1;
         end
      end
   end

   // Running CRC: preset per burst, one step per data edge
   always_ff @(posedge linkClk) begin
      if (linkRst_reg) begin
         crc_reg <= CRC_PRESET;
      end else if ((state_reg == ST_IDLE) && burstReqL) begin
         crc_reg <= CRC_PRESET;                                         // [R16]
      end else if (rxEdge) begin
         crc_reg <= crc_step(crc_reg, pinS2_reg.dd);                    // [R12] [R17] [R21]
      end else if (txFire) begin
         crc_reg <= crc_step(crc_reg, txHold_reg);                      // [R12] [R17] [R21]
      end
   end

   // Received words into the crossing slots, no refusal while active
   always_ff @(posedge linkClk) begin
      if (linkRst_reg) begin
         wrPtr_reg  <= RX_PTR_ZERO;
         wrGray_reg <= RX_PTR_ZERO;
      end else if (rxEdge) begin
         wrPtr_reg  <= wrPtrInc;                                        // [R04] [R11] [R15]
         wrGray_reg <= wrPtrInc ^ (wrPtrInc >> 1);
      end
   end

   // Slot storage written by the same sampled edge as the CRC
   always_ff @(posedge linkClk) begin
      if (rxEdge) begin
         rxSlot[wrPtr_reg] <= pinS2_reg.dd;                             // [R15]
      end
   end

   // Sender: hold word, show it, then strobe unless paused
   always_ff @(posedge linkClk) begin
      if (linkRst_reg) begin
         txHold_reg   <= '0;
         txHoldV_reg  <= 1'b0;
         shown_reg    <= 1'b0;
         txAckTgl_reg <= 1'b0;
         rewTgl_reg   <= 1'b0;
         dStrobe_reg  <= 1'b1;
         ddOut_reg    <= '0;
         ddOe_reg     <= 1'b0;
      end else begin
         ddOe_reg <= (state_reg == ST_XFER) && dirInL;
         if ((state_reg == ST_IDLE) || (state_reg == ST_WAIT_ACK)) begin
            // First data edge of a burst is always a falling one
            dStrobe_reg <= 1'b1;
         end else if (state_reg == ST_END_STROBE) begin
            dStrobe_reg <= 1'b1;                                        // [R13] [R14]
         end else if (txFire) begin
            dStrobe_reg <= !dStrobe_reg;                                // [R05]
         end
         if (txFire) begin
            txHoldV_reg <= 1'b0;
            shown_reg   <= 1'b0;
         end else if (txHoldV_reg && (state_reg == ST_XFER) && dirInL) begin
            // A presented word is not sent until strobed
            ddOut_reg <= txHold_reg;                                    // [R07]
            shown_reg <= 1'b1;
         end else if (!txHoldV_reg && (txReqS_reg[1] != txAckTgl_reg)) begin
            txHold_reg   <= txWord_reg;
            txHoldV_reg  <= 1'b1;
            txAckTgl_reg <= !txAckTgl_reg;
         end
         if ((state_reg == ST_RELEASE) && pinS2_reg.dmackN && txHoldV_reg && !txFire) begin
            // Unstrobed word goes back to its source
            txHoldV_reg <= 1'b0;                                        // [R08]
            shown_reg   <= 1'b0;
            rewTgl_reg  <= !rewTgl_reg;
         end
      end
   end

   // ================= Checks =================

   a_crc_preset_start: assert property (@(posedge linkClk) disable iff (linkRst_reg) // [R16]
      (state_reg == ST_IDLE) && burstReqL |=> (crc_reg == CRC_PRESET))
      else $error("CRC not preset at burst start");

   a_crc_only_edges: assert property (@(posedge linkClk) disable iff (linkRst_reg) // [R12]
      (state_reg == ST_XFER) && !rxEdge && !txFire |=> $stable(crc_reg))
      else $error("CRC moved without a data edge");

   a_crc_step_value: assert property (@(posedge linkClk) disable iff (linkRst_reg) // [R21]
      rxEdge |=> (crc_reg == crc_step($past(crc_reg), $past(pinS2_reg.dd))))
      else $error("CRC step value wrong");

   a_no_strobe_paused: assert property (@(posedge linkClk) disable iff (linkRst_reg) // [R05]
      hostPaused && (state_reg == ST_XFER) |=> $stable(dStrobe_reg))
      else $error("Strobe toggled while host paused");

   a_end_strobe_high: assert property (@(posedge linkClk) disable iff (linkRst_reg) // [R13]
      (state_reg == ST_END_STROBE) |=> dStrobe_reg && $stable(crc_reg))
      else $error("Terminating strobe not high or CRC moved");

   a_settle_before_end: assert property (@(posedge linkClk) disable iff (linkRst_reg) // [R09]
      (state_reg == ST_XFER) && !dirInL && !pinS2_reg.stop && !settled |=> dmarq_reg)
      else $error("Data-out burst ended before the pause settled");

   a_settle_count: assert property (@(posedge linkClk) disable iff (linkRst_reg) // [R09]
      $rose(dReadyN_reg) |-> (pauseCnt_reg == PAUSE_SETTLE_CNT) ##1 !settled)
      else $error("Pause settle count not loaded");

   a_rx_all_taken: assert property (@(posedge linkClk) disable iff (linkRst_reg) // [R11]
      rxEdge |=> (wrPtr_reg == $past(wrPtrInc)) && (rxSlot[$past(wrPtr_reg)] == $past(pinS2_reg.dd)))
      else $error("Received word not stored");

   a_crc_compare: assert property (@(posedge linkClk) disable iff (linkRst_reg) // [R22]
      (state_reg == ST_RELEASE) && pinS2_reg.dmackN |=>
         (crcErrL_reg == (crcIn_reg != $past(crc_reg))) && (state_reg == ST_IDLE))
      else $error("CRC compare result wrong");

   a_ready_hyst: assert property (@(posedge ref_clk) disable iff (rst) // [R03]
      $fell(spaceOk_reg) |-> ($past(fillLevel) >= FILL_HI))
      else $error("Ready level dropped below threshold");

   c_host_pause: cover property (@(posedge linkClk) disable iff (linkRst_reg)
      $rose(dReadyN_reg) ##[1:4] rxEdge);
   c_data_in_end: cover property (@(posedge linkClk) disable iff (linkRst_reg)
      (state_reg == ST_END_STROBE) && !dStrobe_reg);
   c_crc_error: cover property (@(posedge ref_clk) disable iff (rst)
      burstDone_reg && crcError_reg);
   c_rewind: cover property (@(posedge ref_clk) disable iff (rst) txRewind_reg);

endmodule

// ==== udc_pkg.sv ====
// Shared constants and carrier types for the burst pause and CRC block
package udc_pkg;

   // Word and CRC geometry
   localparam int          WORD_W          = 16;
   localparam logic [15:0] CRC_PRESET      = 16'h4ABA;
   localparam logic [15:0] CRC_POLY        = 16'h1021;

   // Clock periods in ns
   localparam int          REF_PERIOD_NS   = 40;
   localparam int          LINK_PERIOD_NS  = 64;

   // Pause settle time in ns and its count of link cycles, rounded up
   localparam int          PAUSE_SETTLE_NS = 200;
   localparam int          PAUSE_SETTLE_CYC =
      (PAUSE_SETTLE_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
   localparam logic [3:0]  PAUSE_SETTLE_CNT = 4'(PAUSE_SETTLE_CYC);
   localparam logic [3:0]  PAUSE_CNT_ZERO   = 4'h0;

   // Extra words after a ready negation: modes 0 to 2, modes 3 to 6
   localparam int          EXTRA_WORDS_SLOW = 2;
   localparam int          EXTRA_WORDS_FAST = 3;
   // Words that sit in the pin synchronisers and the crossing
   localparam int          PIPE_WORDS       = 4;

   // Receive crossing slots
   localparam int          RX_SLOT_W       = 2;
   localparam logic [1:0]  RX_PTR_ONE      = 2'h1;
   localparam logic [1:0]  RX_PTR_ZERO     = 2'h0;

   // Link state machine
   typedef enum logic [2:0] {
      ST_IDLE, ST_WAIT_ACK, ST_XFER, ST_END_STROBE, ST_RELEASE
   } udc_state_t;

   // Pins seen at the device connector, inputs
   typedef struct packed {
      logic              dmackN;    // Host acknowledge, active low
      logic              stop;      // Host stop request
      logic              hStrobe;   // Host strobe, data-out
      logic              hReadyN;   // Host ready, data-in, active low
      logic [WORD_W-1:0] dd;        // Data lines
   } udc_pin_in_t;

   // Pins driven by the device
   typedef struct packed {
      logic              dmarq;     // Burst request
      logic              dReadyN;   // Device ready, data-out, active low
      logic              dStrobe;   // Device strobe, data-in
      logic [WORD_W-1:0] dd;        // Data lines out
      logic              ddOe;      // Data lines output enable
   } udc_pin_out_t;

endpackage

// ==== udc_host_model.sv ====
// Behavioural host end of a data-out or data-in burst facing the device pins
`timescale 1ns/1ps
module udc_host_model
   import udc_pkg::*;
(
   // Device pins seen by the host
   input  wire udc_pin_out_t devPins,
   // Host pins driven toward the device
   output udc_pin_in_t       hostPins
);
   // Idle pins: strobe high, not acknowledged
   initial hostPins = '{1'b1, 1'b0, 1'b1, 1'b1, 16'hFFFF};
   // Acknowledge the request
   task automatic start();
      wait (devPins.dmarq === 1'b1);
      #70 hostPins.dmackN = 1'b0;
   endtask
   // One data word; wait for device ready, then strobe 70 ns later without checking ready again
   task automatic send(input logic [15:0] w);
      wait (devPins.dReadyN === 1'b0);
      hostPins.dd = w;
      #70 hostPins.hStrobe = ~hostPins.hStrobe;
      #300 hostPins.dd = ~w; // stale word is inverted
   endtask
   // Data-in: show ready, take the word at the next device strobe edge
   task automatic recv(output logic [15:0] w);
      hostPins.hReadyN = 1'b0;
      @(devPins.dStrobe) w = devPins.dd;
   endtask
   // Data-in: pause the device by negating ready
   task automatic hold();
      hostPins.hReadyN = 1'b1;
   endtask
   // Stop, restore strobe without data, hand over the CRC
   task automatic finish(input logic [15:0] crc);
      #70 hostPins.stop = 1'b1;
      wait (devPins.dmarq === 1'b0);
      if (!hostPins.hStrobe) hostPins.hStrobe = 1'b1;
      #100 hostPins.dd = crc;
      #70 hostPins.dmackN = 1'b1;
      #300 hostPins.stop = 1'b0;
      hostPins.dd = ~crc;
   endtask
endmodule

// ==== udc_pause_and_crc_tb.sv ====
// Self-checking bench: data-out bursts with pauses, good and bad CRC, and data-in bursts with a host pause
`timescale 1ns/1ps
module udc_pause_and_crc_tb;
   import udc_pkg::*;
   logic ref_clk = 0, linkClk = 0, rst = 1, burstReq = 0, dirIn = 0, txValid = 0;
   logic [7:0] fillLevel = 0;
   logic [31:0] seed = 32'hc78652a0;
   logic [15:0] rxQ[$];
   int n_errors = 0, checks_done = 0, n_done = 0, n_rew = 0;
   udc_pin_in_t pinsIn;
   udc_pin_out_t pinsOut;
   logic rxValid, txReady, txRewind, burstDone, crcError;
   logic [15:0] rxWord, txWord = 0;
   // Clocks of the two domains, phases unrelated
   always #20 ref_clk = ~ref_clk;
   initial #7 forever #32 linkClk = ~linkClk;
   udc_pause_crc DUT (.ref_clk(ref_clk), .rst(rst), .linkClk(linkClk), .pinsIn(pinsIn),
      .pinsOut(pinsOut), .burstReq(burstReq), .dirIn(dirIn), .fillLevel(fillLevel),
      .rxValid(rxValid), .rxWord(rxWord), .txValid(txValid), .txWord(txWord),
      .txReady(txReady), .txRewind(txRewind), .burstDone(burstDone), .crcError(crcError));
   udc_host_model host (.devPins(pinsOut), .hostPins(pinsIn));
   // Collect received words
   always @(posedge ref_clk) if (rxValid === 1'b1) rxQ.push_back(rxWord);
   // Count one-cycle done and rewind pulses so none is missed
   always @(posedge ref_clk) begin
      n_done += (burstDone === 1'b1);
      n_rew += (txRewind === 1'b1);
   end
   function logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Expected CRC: whole word, bit 15 first
   function automatic logic [15:0] crcStep(logic [15:0] c, logic [15:0] d);
      for (int i = 15; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? CRC_POLY : 16'h0000);
      return c;
   endfunction
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic end_sim();
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Hand one word over by valid and ready
   task automatic feed(input logic [15:0] w);
      do @(posedge ref_clk) #1; while (txReady !== 1'b1);
      txWord = w;
      txValid = 1'b1;
      @(posedge ref_clk) #1 txValid = 1'b0;
   endtask
   // Wait for exactly one done pulse beyond d0
   task automatic await_done(input int d0);
      int t = 0;
      do begin @(posedge ref_clk); #1; t++; end while (n_done == d0 && t < 400);
      chk("done", n_done - d0, 1);
   endtask
   // Data-in burst of n words, then a paused word that must come back
   task automatic burst_in(input int n);
      logic [15:0] w, got, crc;
      int d0, r0;
      crc = CRC_PRESET;
      @(posedge ref_clk) #1 dirIn = 1'b1;
      repeat (8) @(posedge ref_clk);
      #1 burstReq = 1'b1;
      host.start();
      for (int i = 0; i < n; i++) begin
         w = 16'(xs());
         crc = crcStep(crc, w);
         feed(w);
         host.recv(got);
         chk("inWord", got, w);
      end
      host.hold();
      w = 16'(xs());
      feed(w);
      repeat (12) @(posedge ref_clk);
      chk("shown", pinsOut.dd, w);
      chk("paused", pinsOut.dStrobe, n % 2 == 0);
      d0 = n_done;
      r0 = n_rew;
      host.finish(crc);
      await_done(d0);
      chk("crcErrIn", crcError, 0);
      chk("rewind", n_rew - r0, 1);
      burstReq = 1'b0;
      dirIn = 1'b0;
      repeat (20) @(posedge ref_clk);
   endtask
   // One burst of n words, optionally with a corrupted CRC
   task automatic burst(input int n, input bit bad);
      logic [15:0] w[$];
      logic [15:0] crc;
      int k;
      crc = CRC_PRESET;
      rxQ = {};
      fillLevel = 8'(xs() % 32);
      @(posedge ref_clk) #1 burstReq = 1'b1;
      host.start();
      for (int i = 0; i < n; i++) begin
         w.push_back(xs() >> 7);
         crc = crcStep(crc, w[i]);
         if (i == 2) begin
            @(posedge ref_clk) #1 fillLevel = 8'(57);
            #700 chk("readyN", pinsOut.dReadyN, 1);
            @(posedge ref_clk) #1 fillLevel = 8'(32);
         end
         host.send(w[i]);
      end
      k = n_done;
      host.finish(bad ? ~crc : crc);
      await_done(k);
      chk("crcErr", crcError, bad);
      chk("count", rxQ.size(), n);
      foreach (w[i]) chk("word", rxQ[i], w[i]);
      burstReq = 1'b0;
      repeat (20) @(posedge ref_clk);
   endtask
   initial begin
      repeat (12) @(posedge ref_clk);
      #1 rst = 0;
      burst(1, 0);
      burst(5, 1);
      for (int b = 0; b < 4; b++) burst(3 + xs() % 6, xs() % 2);
      burst_in(3);
      burst_in(2);
      end_sim();
   end
   initial begin
      #3_000_000 n_errors++;
      end_sim();
   end
endmodule
